// ==== design/rcl_pkg.sv ====
// Purpose: Shared constants and types for the recloser dead-time/close/safety sequencer.
// Assumes: 100 MHz clock, 32-bit register port with byte addresses.
// Notes:   Timer settings are counted in 10 ms ticks.
package rcl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned ATT_W = 3;
  localparam int unsigned NUM_ATT = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DEAD1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DEAD2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DEAD3 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DEAD4 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SYNC_WAIT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CLOSE_FAIL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SAFETY = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_EXT_RESET = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;

  // CTRL field positions
  localparam int unsigned CTRL_LIMIT_LSB = 0;
  localparam int unsigned CTRL_DEP_BIT = 4;
  localparam int unsigned CTRL_SYNC_SUP_LSB = 8;
  localparam int unsigned CTRL_SYNC_WAIT_LSB = 12;

  // STATUS field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_ATT_LSB = 8;
  localparam int unsigned STAT_CAUSE_LSB = 12;
  localparam int unsigned STAT_FIRST3P_BIT = 16;

  localparam logic [ATT_W-1:0] LIMIT_RESET = 3'h1;
  localparam logic [TMR_W-1:0] DEAD_RESET = 16'h0032;
  localparam logic [TMR_W-1:0] SYNC_WAIT_RESET = 16'h01F4;
  localparam logic [TMR_W-1:0] CLOSE_FAIL_RESET = 16'h0032;
  localparam logic [TMR_W-1:0] SAFETY_RESET = 16'h03E8;
  localparam logic [TMR_W-1:0] EXT_RESET_RESET = 16'h01F4;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_START = 8'h02,
    ST_DEAD = 8'h04,
    ST_SYNC_WAIT = 8'h08,
    ST_CLOSING = 8'h10,
    ST_SAFETY = 8'h20,
    ST_LOCKOUT = 8'h40,
    ST_EXT_RESET = 8'h80
  } rcl_state_type;

  typedef enum logic [2:0] {
    LC_NONE = 3'h0,
    LC_NO_SYNC = 3'h1,
    LC_CLOSE_FAIL = 3'h2,
    LC_FINAL_TRIP = 3'h3,
    LC_BRK_OPEN = 3'h4,
    LC_CLOSE_ON_FAULT = 3'h5
  } rcl_cause_type;

  typedef struct packed {
    logic [ATT_W-1:0] limit;
    logic dependent;
    logic [NUM_ATT-1:0] sync_sup;
    logic [NUM_ATT-1:0] sync_wait_en;
  } rcl_cfg_type;

  typedef struct packed {
    logic [TMR_W-1:0] dead1;
    logic [TMR_W-1:0] dead2;
    logic [TMR_W-1:0] dead3;
    logic [TMR_W-1:0] dead4;
    logic [TMR_W-1:0] sync_wait;
    logic [TMR_W-1:0] close_fail;
    logic [TMR_W-1:0] safety;
    logic [TMR_W-1:0] ext_reset;
  } rcl_times_type;

endpackage : rcl_pkg

// ==== design/rcl_timer.sv ====
// Purpose: Tick-counting timer with a programmable terminal count.
// Assumes: tick is a one-cycle pulse; load restarts the count.
// Notes:   A terminal count of zero expires on the first tick.
`timescale 1ns/100ps
module rcl_timer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [rcl_pkg::TMR_W-1:0] limit,
  output logic expired
);
  import rcl_pkg::*;

  logic [TMR_W-1:0] count_q;
  logic expired_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      expired_q <= 1'b0;
    end else if (load) begin
      count_q <= '0;
      expired_q <= 1'b0;
    end else if (tick && !expired_q) begin
      count_q <= count_q + 16'h0001;
      expired_q <= (count_q + 16'h0001) >= limit;
    end
  end

  assign expired = expired_q;

endmodule : rcl_timer

// ==== design/rcl_sequencer.sv ====
// Purpose: Dead time, synchronism check, wait-for-close and safety time of a recloser.
// Assumes: Pins are asynchronous; seq_start and first_trip_3ph come from local logic.
// Notes:   Lockout is left only when the breaker is seen closed.
`timescale 1ns/100ps

// How it works
// - first attempt entering dead time loads the first dead-time setting.
// - second and third attempts load their own dead times, always three-phase.
// - block command during dead time returns to idle, no reclose.
// - per-attempt sync supervision off: dead-time expiry closes at once.
// - supervision on and sync present at expiry: close.
// - sync absent, wait disabled for attempt: lockout for lack of synchronism.
// - wait enabled: sync before wait expiry closes, else no-sync lockout.
// - reclose command drives the breaker close output.
// - close-failure timer expiry with a pole open flags failure and locks out.
// - all poles closed before close-failure expiry enters safety time.
// - reclose command drops when the wait-for-close phase ends.
// - one shared safety timer; expiry without trip returns to idle.
// - trip in safety with limit reached, or dependent after 3-phase, locks out.
// - trip in safety with attempts left goes to the start-time state.
// - pole opening during safety time locks out on breaker open.
// - block command during safety time returns to idle.
// - dead-time value is selected by attempt number, then same sync handling.
// - attempt limit programmable up to four.
// - sequence-in-progress holds from dead time until idle or lockout.
// - lockout waits for breaker closed, then runs the external-close reset time.
module rcl_sequencer #(
  parameter int unsigned TICK_CYCLES = rcl_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [rcl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rcl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [rcl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic seq_start,
  input wire logic first_trip_3ph,
  input wire logic reclose_start_element,
  input wire logic recloser_block_cmd,
  input wire logic sync_ok,
  input wire logic any_pole_open,
  output logic reclose_command,
  output logic breaker_close,
  output logic close_failure_flag,
  output logic sequence_in_progress,
  output logic start_time_request,
  output logic lockout
);
  import rcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int unsigned NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_q;
  logic trip_s;
  logic block_s;
  logic sync_s;
  logic open_s;

  assign pin_raw = {reclose_start_element, recloser_block_cmd, sync_ok, any_pole_open};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          pin_meta_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  assign {trip_s, block_s, sync_s, open_s} = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Tick base

  logic [31:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  rcl_cfg_type cfg_q;
  rcl_times_type times_q;
  rcl_state_type state_q;
  rcl_state_type state_d;
  logic [ATT_W-1:0] att_q;
  logic [ATT_W-1:0] att_d;
  logic first3p_q;
  rcl_cause_type cause_q;
  rcl_cause_type cause_d;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= '{limit: LIMIT_RESET, dependent: 1'b0, sync_sup: '0, sync_wait_en: '0};
      times_q <= '{DEAD_RESET, DEAD_RESET, DEAD_RESET, DEAD_RESET, SYNC_WAIT_RESET,
                   CLOSE_FAIL_RESET, SAFETY_RESET, EXT_RESET_RESET};
    end else if (reg_write) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          // Limit clamped to 1..4 so the safety compare is always meaningful
          if (reg_wdata[CTRL_LIMIT_LSB +: ATT_W] == 3'h0) begin
            cfg_q.limit <= 3'h1;
          end else if (reg_wdata[CTRL_LIMIT_LSB +: ATT_W] > 3'(NUM_ATT)) begin
            cfg_q.limit <= 3'(NUM_ATT);
          end else begin
            cfg_q.limit <= reg_wdata[CTRL_LIMIT_LSB +: ATT_W];
          end
          cfg_q.dependent <= reg_wdata[CTRL_DEP_BIT];
          cfg_q.sync_sup <= reg_wdata[CTRL_SYNC_SUP_LSB +: NUM_ATT];
          cfg_q.sync_wait_en <= reg_wdata[CTRL_SYNC_WAIT_LSB +: NUM_ATT];
        end
        OFS_DEAD1: times_q.dead1 <= reg_wdata[TMR_W-1:0];
        OFS_DEAD2: times_q.dead2 <= reg_wdata[TMR_W-1:0];
        OFS_DEAD3: times_q.dead3 <= reg_wdata[TMR_W-1:0];
        OFS_DEAD4: times_q.dead4 <= reg_wdata[TMR_W-1:0];
        OFS_SYNC_WAIT: times_q.sync_wait <= reg_wdata[TMR_W-1:0];
        OFS_CLOSE_FAIL: times_q.close_fail <= reg_wdata[TMR_W-1:0];
        OFS_SAFETY: times_q.safety <= reg_wdata[TMR_W-1:0];
        OFS_EXT_RESET: times_q.ext_reset <= reg_wdata[TMR_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        OFS_CTRL: reg_rdata <= 32'({cfg_q.sync_wait_en, cfg_q.sync_sup, 3'h0, cfg_q.dependent,
                                    1'b0, cfg_q.limit});
        OFS_DEAD1: reg_rdata <= 32'(times_q.dead1);
        OFS_DEAD2: reg_rdata <= 32'(times_q.dead2);
        OFS_DEAD3: reg_rdata <= 32'(times_q.dead3);
        OFS_DEAD4: reg_rdata <= 32'(times_q.dead4);
        OFS_SYNC_WAIT: reg_rdata <= 32'(times_q.sync_wait);
        OFS_CLOSE_FAIL: reg_rdata <= 32'(times_q.close_fail);
        OFS_SAFETY: reg_rdata <= 32'(times_q.safety);
        OFS_EXT_RESET: reg_rdata <= 32'(times_q.ext_reset);
        OFS_STATUS: reg_rdata <= 32'({first3p_q, 1'b0, cause_q, 1'b0, att_q, state_q});
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer

  logic tmr_load;
  logic tmr_expired;
  logic [TMR_W-1:0] tmr_limit;
  logic [TMR_W-1:0] dead_sel;

  always_comb begin
    unique case (att_d)
      3'h2: dead_sel = times_q.dead2;
      3'h3: dead_sel = times_q.dead3;
      3'h4: dead_sel = times_q.dead4;
      default: dead_sel = times_q.dead1;
    endcase
  end

  always_comb begin
    unique case (state_d)
      ST_DEAD: tmr_limit = dead_sel;
      ST_SYNC_WAIT: tmr_limit = times_q.sync_wait;
      ST_CLOSING: tmr_limit = times_q.close_fail;
      ST_SAFETY: tmr_limit = times_q.safety;
      default: tmr_limit = times_q.ext_reset;
    endcase
  end

  // Every state change restarts the one shared timer; no two timers overlap
  assign tmr_load = state_d != state_q;

  rcl_timer u_timer (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_q),
    .load(tmr_load),
    .limit(tmr_limit),
    .expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state

  logic [ATT_W-1:0] cur_idx;
  assign cur_idx = att_q - 3'h1;

  always_comb begin
    state_d = state_q;
    att_d = att_q;
    cause_d = cause_q;
    unique case (state_q)
      ST_IDLE: begin
        if (seq_start && !block_s) begin
          state_d = ST_DEAD;
          att_d = 3'h1;
        end
      end
      ST_START: begin
        if (block_s) begin
          state_d = ST_IDLE;
        end else if (seq_start) begin
          state_d = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (block_s) begin
          state_d = ST_IDLE;
        end else if (tmr_expired) begin
          if (!cfg_q.sync_sup[cur_idx[1:0]] || sync_s) begin
            state_d = ST_CLOSING;
          end else if (cfg_q.sync_wait_en[cur_idx[1:0]]) begin
            state_d = ST_SYNC_WAIT;
          end else begin
            state_d = ST_LOCKOUT;
            cause_d = LC_NO_SYNC;
          end
        end
      end
      ST_SYNC_WAIT: begin
        if (block_s) begin
          state_d = ST_IDLE;
        end else if (sync_s) begin
          state_d = ST_CLOSING;
        end else if (tmr_expired) begin
          state_d = ST_LOCKOUT;
          cause_d = LC_NO_SYNC;
        end
      end
      ST_CLOSING: begin
        if (!open_s) begin
          state_d = ST_SAFETY;
        end else if (tmr_expired) begin
          state_d = ST_LOCKOUT;
          cause_d = LC_CLOSE_FAIL;
        end
      end
      ST_SAFETY: begin
        if (block_s) begin
          state_d = ST_IDLE;
        end else if (trip_s) begin
          if (att_q >= cfg_q.limit || (cfg_q.dependent && first3p_q)) begin
            state_d = ST_LOCKOUT;
            cause_d = LC_FINAL_TRIP;
          end else begin
            state_d = ST_START;
            att_d = att_q + 3'h1;
          end
        end else if (open_s) begin
          state_d = ST_LOCKOUT;
          cause_d = LC_BRK_OPEN;
        end else if (tmr_expired) begin
          state_d = ST_IDLE;
        end
      end
      ST_LOCKOUT: begin
        if (!open_s) begin
          state_d = ST_EXT_RESET;
        end
      end
      ST_EXT_RESET: begin
        if (trip_s) begin
          state_d = ST_LOCKOUT;
          cause_d = LC_CLOSE_ON_FAULT;
        end else if (tmr_expired) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (state_d == ST_IDLE) begin
      cause_d = LC_NONE;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      att_q <= '0;
      cause_q <= LC_NONE;
    end else begin
      state_q <= state_d;
      att_q <= att_d;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first3p_q <= 1'b0;
    end else if (state_q == ST_IDLE && state_d == ST_DEAD) begin
      first3p_q <= first_trip_3ph;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered from the next state

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reclose_command <= 1'b0;
      breaker_close <= 1'b0;
      close_failure_flag <= 1'b0;
      sequence_in_progress <= 1'b0;
      start_time_request <= 1'b0;
      lockout <= 1'b0;
    end else begin
      reclose_command <= state_d == ST_CLOSING;
      breaker_close <= state_d == ST_CLOSING;
      // Cause outlives lockout into the reset time; flag must not
      close_failure_flag <= state_d == ST_LOCKOUT && cause_d == LC_CLOSE_FAIL;
      sequence_in_progress <= state_d inside {ST_START, ST_DEAD, ST_SYNC_WAIT,
                                              ST_CLOSING, ST_SAFETY};
      start_time_request <= state_d == ST_START;
      lockout <= state_d == ST_LOCKOUT;
    end
  end

endmodule : rcl_sequencer

// ==== dv/rcl_seq_chk.sv ====
// Purpose: Port-level checks of the recloser sequencer.
// Assumes: Pins pass a two-stage synchroniser before the state machine.
// Notes:   Windows allow for that synchroniser depth.
`timescale 1ns/100ps
module rcl_seq_chk #(
  parameter int unsigned TICK_CYCLES = rcl_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic recloser_block_cmd,
  input wire logic any_pole_open,
  input wire logic reclose_command,
  input wire logic breaker_close,
  input wire logic close_failure_flag,
  input wire logic sequence_in_progress,
  input wire logic start_time_request,
  input wire logic lockout
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////
  AST_CLOSE_MIRROR: assert property (breaker_close == reclose_command)
    else $error("close output differs from reclose command");
  AST_LOCK_QUIET: assert property (lockout |-> !reclose_command && !sequence_in_progress)
    else $error("activity while locked out");
  AST_FAIL_IN_LOCK: assert property (close_failure_flag |-> lockout)
    else $error("close failure flag outside lockout");
  AST_FAIL_CAUSE: assert property ($rose(close_failure_flag) |->
    $past(reclose_command) && $past(any_pole_open, 3))
    else $error("close failure without pending close");
  AST_CMD_IN_SEQ: assert property (reclose_command |->
    sequence_in_progress && !start_time_request)
    else $error("reclose command outside sequence");
  AST_CLOSED_DROP: assert property ($fell(reclose_command) && !close_failure_flag |->
    sequence_in_progress && !$past(any_pole_open, 3))
    else $error("reclose dropped without breaker closed");
  AST_BLOCK_NO_CLOSE: assert property ($rose(reclose_command) |-> !($past(recloser_block_cmd, 2)
    && $past(recloser_block_cmd, 3) && $past(recloser_block_cmd, 4)))
    else $error("reclose issued while blocked");
  AST_BLOCK_IDLE: assert property ($rose(recloser_block_cmd) && sequence_in_progress &&
    !reclose_command && !start_time_request |->
    ##[1:4] (!sequence_in_progress || reclose_command))
    else $error("block did not end the sequence");
  AST_LOCK_HOLD: assert property (any_pole_open [*4] ##0 lockout |=> lockout)
    else $error("lockout left with breaker open");
  COV_CLOSE: cover property ($rose(reclose_command));
  COV_FAIL: cover property ($rose(close_failure_flag));
  COV_NEXT: cover property ($rose(start_time_request));
endmodule : rcl_seq_chk

// ==== dv/rcl_breaker_model.sv ====
// Purpose: Breaker pole status model for the recloser bench.
// Assumes: mode 0 closes promptly, 2 slowly, 1 never (stuck).
// Notes:   trip_open opens all poles; manual_close closes them at once.
`timescale 1ns/100ps
module rcl_breaker_model #(
  parameter int unsigned FAST_CYCLES = 2,
  parameter int unsigned SLOW_CYCLES = 20
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic breaker_close,
  input wire logic trip_open,
  input wire logic manual_close,
  input wire logic [1:0] mode,
  output logic any_pole_open
);
  int unsigned wait_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      any_pole_open <= 1'h0;
      wait_q <= 0;
    end else if (trip_open) begin
      any_pole_open <= 1'h1;
    end else if (manual_close) begin
      any_pole_open <= 1'h0;
    end else if (breaker_close && any_pole_open && mode != 2'h1) begin
      wait_q <= wait_q + 1;
      if (wait_q == ((mode == 2'h2) ? SLOW_CYCLES : FAST_CYCLES)) begin
        any_pole_open <= 1'h0;
      end
    end else begin
      wait_q <= 0;
    end
  end
endmodule : rcl_breaker_model

// ==== dv/rcl_sequencer_tb_top.sv ====
// Purpose: Self-checking bench of the recloser sequencer.
// Assumes: Short tick (10 cycles) and short timer settings.
// Notes:   Each row runs one sequence from a trip to its final state.
`timescale 1ns/100ps
module rcl_sequencer_tb_top;
  import rcl_pkg::*;
  typedef struct {logic [15:0] ctrl; logic sync; int rise; logic [1:0] brk; int ev;
    logic [7:0] st; logic [2:0] cause;} rcl_row_type;
  logic clock = 1'h0, resetn = 1'h0, reg_write = 1'h0, reg_read = 1'h0, seq_start = 1'h0;
  logic first_trip_3ph = 1'h0, reclose_start_element = 1'h0, recloser_block_cmd = 1'h0;
  logic sync_ok = 1'h0, trip_open = 1'h0, manual_close = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reclose_command, breaker_close, close_failure_flag, sequence_in_progress;
  logic start_time_request, lockout, any_pole_open;
  int miscompares = 0, n_tests = 0;
  // ev: 1 trip, 2 pole open, 3 block in safety time; 4 block in dead time
  rcl_row_type rows [13] = '{
    '{16'h0001, 1'h0, 0, 2'h0, 0, ST_IDLE, LC_NONE},
    '{16'h0101, 1'h1, 0, 2'h2, 0, ST_IDLE, LC_NONE},
    '{16'h0101, 1'h0, 0, 2'h0, 0, ST_LOCKOUT, LC_NO_SYNC},
    '{16'h1101, 1'h0, 0, 2'h0, 0, ST_LOCKOUT, LC_NO_SYNC},
    '{16'h1101, 1'h0, 60, 2'h0, 0, ST_IDLE, LC_NONE},
    '{16'h0001, 1'h0, 0, 2'h1, 0, ST_LOCKOUT, LC_CLOSE_FAIL},
    '{16'h0001, 1'h0, 0, 2'h0, 1, ST_LOCKOUT, LC_FINAL_TRIP},
    '{16'h0001, 1'h0, 0, 2'h0, 2, ST_LOCKOUT, LC_BRK_OPEN},
    '{16'h0001, 1'h0, 0, 2'h0, 3, ST_IDLE, LC_NONE},
    '{16'h0001, 1'h0, 0, 2'h0, 4, ST_IDLE, LC_NONE},
    '{16'h0012, 1'h0, 0, 2'h0, 1, ST_LOCKOUT, LC_FINAL_TRIP},
    '{16'h0202, 1'h0, 0, 2'h0, 1, ST_START, LC_NONE},
    '{16'h0202, 1'h0, 0, 2'h0, 0, ST_LOCKOUT, LC_NO_SYNC}};
  always #5 clock = ~clock;
  rcl_sequencer #(.TICK_CYCLES(10)) rcl_sequencer_inst (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .seq_start(seq_start), .first_trip_3ph(first_trip_3ph),
    .reclose_start_element(reclose_start_element), .recloser_block_cmd(recloser_block_cmd),
    .sync_ok(sync_ok), .any_pole_open(any_pole_open), .reclose_command(reclose_command),
    .breaker_close(breaker_close), .close_failure_flag(close_failure_flag),
    .sequence_in_progress(sequence_in_progress), .start_time_request(start_time_request),
    .lockout(lockout));
  rcl_breaker_model rcl_breaker_model_inst (.clock(clock), .resetn(resetn),
    .breaker_close(breaker_close), .trip_open(trip_open), .manual_close(manual_close),
    .mode(mode), .any_pole_open(any_pole_open));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'h0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic run_row(input rcl_row_type r);
    int k_safe;
    logic seen;
    logic [31:0] d;
    k_safe = 0;
    seen = 1'h0;
    wr(OFS_CTRL, {16'h0000, r.ctrl});
    sync_ok <= r.sync;
    first_trip_3ph <= r.ctrl[4];
    mode <= r.brk;
    trip_open <= 1'h1;
    @(posedge clock);
    trip_open <= 1'h0;
    repeat (4) @(posedge clock);
    seq_start <= 1'h1;
    @(posedge clock);
    seq_start <= 1'h0;
    for (int k = 1; k < 3000; k++) begin
      @(posedge clock);
      #1 seen = seen | reclose_command;
      if (seen && !reclose_command && k_safe == 0) k_safe = k;
      if (k == r.rise) sync_ok <= 1'h1;
      if (r.ev == 4 && k == 5) recloser_block_cmd <= 1'h1;
      if (k_safe != 0 && k == k_safe + 10 && r.ev > 0 && r.ev < 4) begin
        reclose_start_element <= (r.ev == 1);
        trip_open <= (r.ev != 3);
        recloser_block_cmd <= (r.ev == 3);
      end
      if (k_safe != 0 && k == k_safe + 11) trip_open <= 1'h0;
      if (k > 3 && (!sequence_in_progress || start_time_request)) break;
    end
    repeat (4) @(posedge clock);
    reclose_start_element <= 1'h0;
    recloser_block_cmd <= 1'h0;
    rd(OFS_STATUS, d);
    chk({(r.st == ST_LOCKOUT) ? d[14:12] : 3'h0, d[7:0]}, {r.cause, r.st});
    chk(close_failure_flag, r.cause == LC_CLOSE_FAIL);
    chk(seen, r.cause != LC_NO_SYNC && r.ev != 4);
    if (lockout === 1'h1) begin
      manual_close <= 1'h1;
      @(posedge clock);
      manual_close <= 1'h0;
      for (int k = 0; k < 20 && lockout !== 1'h0; k++) @(posedge clock);
      // Ext reset time is 5 ticks of 10 cycles
      repeat (80) @(posedge clock);
      rd(OFS_STATUS, d);
      chk(d[7:0], ST_IDLE);
    end
  endtask : run_row
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge clock);
    chk({reclose_command, breaker_close, close_failure_flag, lockout}, 32'h0);
    resetn <= 1'h1;
    rd(OFS_CTRL, d);
    chk(d, 32'h0000_0001);
    rd(OFS_SAFETY, d);
    chk(d, 32'h0000_03E8);
    wr(OFS_CTRL, 32'h0000_0007);
    rd(OFS_CTRL, d);
    chk(d[2:0], 3'h4);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, d);
    chk(d, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_00FF);
    rd(OFS_STATUS, d);
    chk(d[7:0], ST_IDLE);
    for (int i = 0; i < 4; i++) wr(OFS_DEAD1 + 8'(4 * i), 32'h0000_0003);
    wr(OFS_SYNC_WAIT, 32'h0000_000A);
    wr(OFS_CLOSE_FAIL, 32'h0000_0005);
    wr(OFS_SAFETY, 32'h0000_0014);
    wr(OFS_EXT_RESET, 32'h0000_0005);
    foreach (rows[i]) run_row(rows[i]);
    // Trip while the external-close reset time runs: locks out again
    wr(OFS_CTRL, 32'h0000_0101);
    trip_open <= 1'h1;
    seq_start <= 1'h1;
    @(posedge clock);
    trip_open <= 1'h0;
    seq_start <= 1'h0;
    repeat (40) @(posedge clock);
    chk(lockout, 1'h1);
    manual_close <= 1'h1;
    @(posedge clock);
    manual_close <= 1'h0;
    repeat (6) @(posedge clock);
    reclose_start_element <= 1'h1;
    trip_open <= 1'h1;
    @(posedge clock);
    trip_open <= 1'h0;
    repeat (5) @(posedge clock);
    reclose_start_element <= 1'h0;
    rd(OFS_STATUS, d);
    chk({d[14:12], d[7:0]}, {LC_CLOSE_ON_FAULT, ST_LOCKOUT});
    // Reset in mid-run: lockout dropped, registers back to defaults
    resetn <= 1'h0;
    repeat (2) @(posedge clock);
    chk({lockout, close_failure_flag}, 32'h0);
    resetn <= 1'h1;
    rd(OFS_STATUS, d);
    chk(d, 32'h0000_0001);
    rd(OFS_CTRL, d);
    chk(d, 32'h0000_0001);
    end_of_test();
  end
  // About eighteen times the expected run length
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
endmodule : rcl_sequencer_tb_top

bind rcl_sequencer rcl_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) rcl_seq_chk_inst (
  .clock(clock), .resetn(resetn), .recloser_block_cmd(recloser_block_cmd),
  .any_pole_open(any_pole_open), .reclose_command(reclose_command),
  .breaker_close(breaker_close), .close_failure_flag(close_failure_flag),
  .sequence_in_progress(sequence_in_progress), .start_time_request(start_time_request),
  .lockout(lockout));
